// ---- rtl/pcc_clk_switch.v ----
// Base clock selector: glitch-free source change with freeze, then divide by two
`timescale 1ns/10ps
`include "pcc_defines.vh"
module pcc_clk_switch (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst_n,
    // Source rising-edge strobes
    input  wire xclk_rise,
    input  wire vclk_rise,
    // Requested source, 1 selects the VCO
    input  wire select_req,
    // Outputs
    output reg  base_clock_out,
    output reg  switching_out
);

    reg       active_sel_reg;
    reg [1:0] xcnt_reg;
    reg [1:0] vcnt_reg;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_sel_reg <= 1'b0;
            xcnt_reg       <= 2'h0;
            vcnt_reg       <= 2'h0;
            base_clock_out <= 1'b0;
            switching_out  <= 1'b0;
        end else if (select_req != active_sel_reg) begin
            // Output frozen until both sources have shown their edges
            switching_out <= 1'b1;
            if (xclk_rise && xcnt_reg != `PCC_SWITCH_EDGES) begin
                xcnt_reg <= xcnt_reg + 2'h1;
            end
            if (vclk_rise && vcnt_reg != `PCC_SWITCH_EDGES) begin
                vcnt_reg <= vcnt_reg + 2'h1;
            end
            if (xcnt_reg == `PCC_SWITCH_EDGES && vcnt_reg == `PCC_SWITCH_EDGES) begin
                active_sel_reg <= select_req;
                xcnt_reg       <= 2'h0;
                vcnt_reg       <= 2'h0;
            end
        end else begin
            switching_out <= 1'b0;
            xcnt_reg      <= 2'h0;
            vcnt_reg      <= 2'h0;
            // Toggling on each rising edge gives half rate at 50% duty
            if (active_sel_reg ? vclk_rise : xclk_rise) begin
                base_clock_out <= ~base_clock_out;
            end
        end
    end

endmodule // pcc_clk_switch

// ---- rtl/pcc_pll_clock_control.v ----
// PLL clock control and status registers with AXI4-Lite slave and base clock selection
//
// Behaviour
// - Lock interrupt enable writable only in automatic mode, else reads zero; reset clears.
// - Lock indicator toggle sets change flag in automatic mode only; with enable set it requests an interrupt.
// - Change flag reads zero in manual mode; read-only; reset clears.
// - Any control register read clears the change flag, unless a lock toggle sets it in the same cycle.
// - Power-on bit enables loop and VCO clock; reset sets it.
// - Power-on cannot be cleared while base clock select is set.
// - Base clock select cannot be set while power-on is clear.
// - Select one gives VCO/2 output, zero gives crystal/2; reset clears select.
// - Source switch waits three edges of each clock, output frozen meanwhile.
// - Prescaler field codes 1,2,4,8; locked while loop on; reset clears.
// - VCO range power field codes 1,2,4,8; locked while loop on; reset clears.
// - Automatic bandwidth bit read/write, one automatic, zero manual; reset clears.
// - Lock indicator shows lock in automatic mode, reads zero in manual mode.
// - Base clock output has 50% duty, made by dividing source by two.
// - Single interrupt output carries the lock change request.
// - Oscillator and loop enabled only while oscillator enable input is high.
// - Tracking select shows loop state in automatic mode, forces it in manual.
// - Zero linear range multiplier disables loop and forces crystal source.
`timescale 1ns/10ps
`include "pcc_defines.vh"
module pcc_pll_clock_control #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input  wire              ref_clk,
    input  wire              rst_n,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Source clocks, sampled
    input  wire              crystal_clock,
    input  wire              vco_clock,
    // Analog loop status, asynchronous
    input  wire              lock_detect_in,
    input  wire              loop_tracking_in,
    // System integration unit and range register, same clock
    input  wire              oscillator_enable_in,
    input  wire              vco_range_is_zero,
    // Analog controls
    output reg               crystal_osc_enable_out,
    output reg               pll_enable_out,
    output reg  [1:0]        prescaler_field_out,
    output reg  [1:0]        vco_range_power_field_out,
    output reg               auto_bandwidth_out,
    output reg               tracking_force_out,
    // Base clock and interrupt
    output wire              base_clock_out,
    output wire              clock_switching_out,
    output reg               lock_interrupt_out
);

    // Map a byte address onto a register selector
    function [1:0] pcc_decode;
        input [ADDR_W-1:0] addr;
        begin
            if (addr == `PCC_OFS_CONTROL) begin
                pcc_decode = `PCC_SEL_CONTROL;
            end else if (addr == `PCC_OFS_BANDWIDTH) begin
                pcc_decode = `PCC_SEL_BANDWIDTH;
            end else begin
                pcc_decode = `PCC_SEL_NONE;
            end
        end
    endfunction

    // Register state
    reg        irq_en_reg;
    reg        flag_reg;
    reg        pwr_on_reg;
    reg        base_sel_reg;
    reg [1:0]  presc_reg;
    reg [1:0]  range_reg;
    reg        auto_reg;
    reg        track_reg;

    // Bus holding state
    reg [ADDR_W-1:0] aw_addr_reg;
    reg              aw_held_reg;
    reg [31:0]       wdata_reg;
    reg              wbyte_en_reg;
    reg              w_held_reg;

    // Synchronised inputs
    wire [3:0] sync_level;
    wire [3:0] sync_change;
    wire       lock_sync;
    wire       track_sync;
    wire       lock_toggle;
    wire       xclk_rise;
    wire       vclk_rise;

    pcc_sync_edge #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .async_in   ({vco_clock, crystal_clock, loop_tracking_in, lock_detect_in}),
        .level_out  (sync_level),
        .change_out (sync_change)
    );

    assign lock_sync   = sync_level[0];
    assign track_sync  = sync_level[1];
    assign lock_toggle = sync_change[0];
    assign xclk_rise   = sync_level[2] & sync_change[2];
    assign vclk_rise   = sync_level[3] & sync_change[3];

    // A stopped VCO must not hold back a switch to the crystal
    wire       vclk_count;
    assign vclk_count  = vclk_rise | (~pll_enable_out & ~base_sel_reg);

    // Clocks are sampled, so the VCO must run below half of ref_clk
    pcc_clk_switch u_switch (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .xclk_rise      (xclk_rise),
        .vclk_rise      (vclk_count),
        .select_req     (base_sel_reg),
        .base_clock_out (base_clock_out),
        .switching_out  (clock_switching_out)
    );

    // Readback values
    wire [7:0] ctl_read;
    wire [7:0] bw_read;
    wire       lock_read;
    wire       track_read;

    assign lock_read  = auto_reg & lock_sync;
    assign track_read = auto_reg ? track_sync : track_reg;
    assign ctl_read   = {irq_en_reg & auto_reg,
                         flag_reg & auto_reg,
                         pwr_on_reg, base_sel_reg, presc_reg, range_reg};
    assign bw_read    = {auto_reg, lock_read, track_read, 5'h00};

    // Bus events
    wire       aw_fire;
    wire       w_fire;
    wire       ar_fire;
    wire       wr_do;
    wire [1:0] wr_sel;
    wire [1:0] rd_sel;
    wire       ctl_read_now;
    wire       flag_set;

    assign aw_fire      = s_axi_awvalid & s_axi_awready;
    assign w_fire       = s_axi_wvalid & s_axi_wready;
    assign ar_fire      = s_axi_arvalid & s_axi_arready;
    assign wr_do        = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_sel       = pcc_decode(aw_addr_reg);
    assign rd_sel       = pcc_decode(s_axi_araddr);
    assign ctl_read_now = ar_fire & (rd_sel == `PCC_SEL_CONTROL);
    assign flag_set     = lock_toggle & auto_reg;

    // Write channel capture, address and data in either order
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_addr_reg   <= {ADDR_W{1'b0}};
            aw_held_reg   <= 1'b0;
            wdata_reg     <= 32'h0000_0000;
            wbyte_en_reg  <= 1'b0;
            w_held_reg    <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PCC_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                wdata_reg    <= s_axi_wdata;
                wbyte_en_reg <= s_axi_wstrb[0];
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == `PCC_SEL_NONE) ? `PCC_RESP_SLVERR : `PCC_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel, answer one cycle after the address is taken
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PCC_RESP_OKAY;
        end else begin
            if (ar_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                case (rd_sel)
                    `PCC_SEL_CONTROL: begin
                        s_axi_rdata <= {24'h00_0000, ctl_read};
                        s_axi_rresp <= `PCC_RESP_OKAY;
                    end
                    `PCC_SEL_BANDWIDTH: begin
                        s_axi_rdata <= {24'h00_0000, bw_read};
                        s_axi_rresp <= `PCC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `PCC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Lock change flag; a new toggle outranks a same-cycle read
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= `PCC_RST_FLAG;
        end else if (flag_set) begin
            flag_reg <= 1'b1;
        end else if (ctl_read_now) begin
            flag_reg <= 1'b0;
        end
    end

    // Control register writes with interlocks judged on the old values
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg   <= `PCC_RST_IRQ_EN;
            pwr_on_reg   <= `PCC_RST_PWR_ON;
            base_sel_reg <= `PCC_RST_BASE_SEL;
            presc_reg    <= `PCC_RST_PRESC;
            range_reg    <= `PCC_RST_RANGE;
        end else begin
            if (wr_do && wbyte_en_reg && wr_sel == `PCC_SEL_CONTROL) begin
                if (auto_reg) begin
                    irq_en_reg <= wdata_reg[`PCC_CTL_IRQ_EN_BIT];
                end
                // Clearing power is refused while the VCO drives the base clock
                pwr_on_reg <= wdata_reg[`PCC_CTL_PWR_ON_BIT] | base_sel_reg;
                // Old power state gates select, so one write cannot do both
                base_sel_reg <= wdata_reg[`PCC_CTL_BASE_SEL_BIT] & pwr_on_reg
                                & ~vco_range_is_zero;
                if (!pwr_on_reg) begin
                    presc_reg <= wdata_reg[`PCC_CTL_PRESC_HI:`PCC_CTL_PRESC_LO];
                    range_reg <= wdata_reg[`PCC_CTL_RANGE_HI:`PCC_CTL_RANGE_LO];
                end
            end else if (vco_range_is_zero) begin
                base_sel_reg <= 1'b0;
            end
        end
    end

    // Bandwidth control writes; lock position is ignored
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_reg  <= `PCC_RST_AUTO;
            track_reg <= `PCC_RST_TRACK;
        end else if (wr_do && wbyte_en_reg && wr_sel == `PCC_SEL_BANDWIDTH) begin
            auto_reg <= wdata_reg[`PCC_BW_AUTO_BIT];
            // Manual value is kept aside in automatic mode and returns afterwards
            if (!auto_reg) begin
                track_reg <= wdata_reg[`PCC_BW_TRACK_BIT];
            end
        end
    end

    // Registered drives toward the analog loop and the CPU
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crystal_osc_enable_out    <= 1'b0;
            pll_enable_out            <= 1'b0;
            prescaler_field_out       <= `PCC_RST_PRESC;
            vco_range_power_field_out <= `PCC_RST_RANGE;
            auto_bandwidth_out        <= `PCC_RST_AUTO;
            tracking_force_out        <= `PCC_RST_TRACK;
            lock_interrupt_out        <= 1'b0;
        end else begin
            crystal_osc_enable_out    <= oscillator_enable_in;
            pll_enable_out            <= pwr_on_reg & oscillator_enable_in
                                         & ~vco_range_is_zero;
            prescaler_field_out       <= presc_reg;
            vco_range_power_field_out <= range_reg;
            auto_bandwidth_out        <= auto_reg;
            tracking_force_out        <= track_reg;
            lock_interrupt_out        <= flag_reg & irq_en_reg & auto_reg;
        end
    end

endmodule // pcc_pll_clock_control

// ---- rtl/pcc_sync_edge.v ----
// Two-stage synchroniser with a change detector on the synchronised level
`timescale 1ns/10ps
module pcc_sync_edge #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // Asynchronous levels in
    input  wire [WIDTH-1:0] async_in,
    // Synchronised levels and change pulses out
    output wire [WIDTH-1:0] level_out,
    output wire [WIDTH-1:0] change_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] stable_reg;
    reg [WIDTH-1:0] prev_reg;

    // First stage feeds only the second; the detector compares later stages
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg   <= {WIDTH{1'b0}};
            stable_reg <= {WIDTH{1'b0}};
            prev_reg   <= {WIDTH{1'b0}};
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
            prev_reg   <= stable_reg;
        end
    end

    assign level_out  = stable_reg;
    assign change_out = stable_reg ^ prev_reg;

endmodule // pcc_sync_edge

// ---- shared/pcc_defines.vh ----
// Register map, field positions, reset values and timing counts for the PLL clock control block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// Register byte offsets
`define PCC_OFS_CONTROL        12'h000
`define PCC_OFS_BANDWIDTH      12'h004

// Control register fields
`define PCC_CTL_IRQ_EN_BIT     7
`define PCC_CTL_FLAG_BIT       6
`define PCC_CTL_PWR_ON_BIT     5
`define PCC_CTL_BASE_SEL_BIT   4
`define PCC_CTL_PRESC_HI       3
`define PCC_CTL_PRESC_LO       2
`define PCC_CTL_RANGE_HI       1
`define PCC_CTL_RANGE_LO       0

// Bandwidth control register fields
`define PCC_BW_AUTO_BIT        7
`define PCC_BW_LOCK_BIT        6
`define PCC_BW_TRACK_BIT       5

// Reset values
`define PCC_RST_IRQ_EN         1'b0
`define PCC_RST_FLAG           1'b0
`define PCC_RST_PWR_ON         1'b1
`define PCC_RST_BASE_SEL       1'b0
`define PCC_RST_PRESC          2'h0
`define PCC_RST_RANGE          2'h0
`define PCC_RST_AUTO           1'b0
`define PCC_RST_TRACK          1'b0

// Source edges counted on each side before a base clock switch completes
`define PCC_SWITCH_EDGES       2'h3

// Bus responses
`define PCC_RESP_OKAY          2'h0
`define PCC_RESP_SLVERR        2'h2

// Register selector codes
`define PCC_SEL_NONE           2'h0
`define PCC_SEL_CONTROL        2'h1
`define PCC_SEL_BANDWIDTH      2'h2

`endif

// ---- tb/pcc_checker.sv ----
// Port-level assertions for the PLL clock control block
`timescale 1ns/10ps
module pcc_checker #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input wire              ref_clk,
    input wire              rst_n,
    // Register bus
    input wire              s_axi_awvalid,
    input wire              s_axi_awready,
    input wire              s_axi_wvalid,
    input wire              s_axi_wready,
    input wire [1:0]        s_axi_bresp,
    input wire              s_axi_bvalid,
    input wire              s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire [31:0]       s_axi_rdata,
    input wire              s_axi_rvalid,
    input wire              s_axi_rready,
    // Enables and controls
    input wire              oscillator_enable_in,
    input wire              vco_range_is_zero,
    input wire              crystal_osc_enable_out,
    input wire              pll_enable_out,
    input wire [1:0]        prescaler_field_out,
    input wire [1:0]        vco_range_power_field_out,
    input wire              auto_bandwidth_out,
    input wire              lock_interrupt_out
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    irq_gate_a: assert property (lock_interrupt_out |-> auto_bandwidth_out)
        else $error("lock interrupt raised in manual mode");
    // The flag clears at the read handshake, so the request must drop soon after
    irq_clear_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 0 && lock_interrupt_out
        |-> ##[1:2] !lock_interrupt_out)
        else $error("control read left the lock interrupt up");
    osc_follow_a: assert property (crystal_osc_enable_out |-> $past(oscillator_enable_in))
        else $error("oscillator enabled without the enable input");
    loop_enable_a: assert property (pll_enable_out
        |-> $past(oscillator_enable_in) && !$past(vco_range_is_zero))
        else $error("loop enabled while disallowed");
    field_lock_a: assert property ($past(pll_enable_out) && pll_enable_out
        |-> $stable(prescaler_field_out) && $stable(vco_range_power_field_out))
        else $error("range fields changed while loop on");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 0)
        else $error("read not answered or upper bits set");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
endmodule // pcc_checker

// ---- tb/pcc_loop_model.sv ----
// Behavioural model of the oscillator and analog loop beside the block
`timescale 1ns/10ps
module pcc_loop_model #(
    parameter XHALF = 200,
    parameter VHALF = 140
) (
    // Enables from the block
    input  wire  xosc_en,
    input  wire  pll_en,
    // Commands from the bench
    input  wire  lock_req,
    input  wire  track_req,
    // Loop outputs
    output logic crystal_clock,
    output logic vco_clock,
    output wire  lock_detect_in,
    output wire  loop_tracking_in
);
    initial crystal_clock = 1'b0;
    initial vco_clock = 1'b0;
    // Oscillator stands still while not enabled
    always #(XHALF) crystal_clock = xosc_en ? ~crystal_clock : 1'b0;
    // VCO runs only with the loop on
    always #(VHALF) vco_clock = pll_en ? ~vco_clock : 1'b0;
    // A loop that is off can neither lock nor track
    assign lock_detect_in   = lock_req & pll_en;
    assign loop_tracking_in = track_req & pll_en;
endmodule // pcc_loop_model

// ---- tb/pcc_pll_clock_control_tb.sv ----
// Self-checking bench for the PLL clock control block
`timescale 1ns/10ps
`include "pcc_defines.vh"
module pcc_pll_clock_control_tb;
    localparam logic [11:0] CTL = `PCC_OFS_CONTROL;
    localparam logic [11:0] BW  = `PCC_OFS_BANDWIDTH;
    logic        ref_clk = 1'b0, rst_n = 1'b0, lock_req = 1'b0, track_req = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        oscillator_enable_in = 1'b1, vco_range_is_zero = 1'b0;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, prescaler_field_out, vco_range_power_field_out;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         crystal_clock, vco_clock, lock_detect_in, loop_tracking_in, crystal_osc_enable_out;
    wire         pll_enable_out, auto_bandwidth_out, tracking_force_out, base_clock_out;
    wire         clock_switching_out, lock_interrupt_out;
    logic [33:0] expq[$];
    int          mismatches = 0, n_tests = 0;
    logic [7:0]  v;

    always #10 ref_clk = ~ref_clk;

    pcc_pll_clock_control dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystal_clock,
        .vco_clock, .lock_detect_in, .loop_tracking_in, .oscillator_enable_in, .vco_range_is_zero,
        .crystal_osc_enable_out, .pll_enable_out, .prescaler_field_out, .vco_range_power_field_out,
        .auto_bandwidth_out, .tracking_force_out, .base_clock_out, .clock_switching_out, .lock_interrupt_out);

    pcc_loop_model loop_i (.xosc_en(crystal_osc_enable_out), .pll_en(pll_enable_out), .lock_req, .track_req,
        .crystal_clock, .vco_clock, .lock_detect_in, .loop_tracking_in);

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Oldest note is matched against each bus answer as it is taken
    always @(posedge ref_clk) begin
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expq.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    end

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        expq.push_back({r, w ? 32'h0 : {24'h0, d}});
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (w ? s_axi_bvalid : s_axi_rvalid) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            mismatches++;
            complete_run();
        end
        // One idle edge so the next request never reassigns a ready in the same step
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, `PCC_RESP_OKAY);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b0, a, d, `PCC_RESP_OKAY);
    endtask

    // Counts base clock rises over 600 cycles once any source switch is over
    task automatic freq(input int lo, input int hi);
        int n, c;
        logic p;
        for (n = 0; n < 300 && (n < 8 || clock_switching_out !== 1'b0); n++) @(posedge ref_clk);
        if (clock_switching_out !== 1'b0) begin
            mismatches++;
            complete_run();
        end
        c = 0;
        p = base_clock_out;
        repeat (600) begin
            @(posedge ref_clk);
            if (base_clock_out && !p) c++;
            p = base_clock_out;
        end
        chk(c >= lo && c <= hi, 1'b1);
    endtask

    task automatic wait_irq;
        int n;
        for (n = 0; n < 20 && lock_interrupt_out !== 1'b1; n++) @(posedge ref_clk);
        chk(lock_interrupt_out, 1'b1);
        if (lock_interrupt_out !== 1'b1) complete_run();
    endtask

    initial begin
        void'($urandom(79));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(CTL, 8'h20);
        rd(BW, 8'h00);
        wr(CTL, 8'h2f);
        rd(CTL, 8'h20);
        wr(CTL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = {4'h0, i[1:0], 2'($urandom)};
            wr(CTL, v);
            rd(CTL, v);
            chk({prescaler_field_out, vco_range_power_field_out}, v[3:0]);
        end
        wr(CTL, 8'h1f);
        rd(CTL, 8'h0f);
        freq(14, 16);
        wr(CTL, 8'h20);
        wr(CTL, 8'h30);
        rd(CTL, 8'h30);
        freq(20, 22);
        wr(CTL, 8'h10);
        rd(CTL, 8'h30);
        wr(CTL, 8'h20);
        freq(14, 16);
        wr(CTL, 8'h30);
        freq(20, 22);
        vco_range_is_zero <= 1'b1;
        wr(CTL, 8'h30);
        rd(CTL, 8'h20);
        chk(pll_enable_out, 1'b0);
        freq(14, 16);
        vco_range_is_zero <= 1'b0;
        wr(CTL, 8'ha0);
        rd(CTL, 8'h20);
        track_req <= 1'b1;
        wr(BW, 8'h80);
        rd(BW, 8'ha0);
        wr(CTL, 8'ha0);
        rd(CTL, 8'ha0);
        lock_req <= 1'b1;
        wait_irq();
        rd(BW, 8'he0);
        rd(CTL, 8'he0);
        rd(CTL, 8'ha0);
        chk(lock_interrupt_out, 1'b0);
        lock_req <= 1'b0;
        wr(CTL, 8'h20);
        rd(CTL, 8'h60);
        lock_req <= 1'b1;
        wr(CTL, 8'ha0);
        wait_irq();
        wr(BW, 8'h00);
        rd(CTL, 8'h20);
        chk(lock_interrupt_out, 1'b0);
        wr(BW, 8'h20);
        rd(BW, 8'h20);
        chk(tracking_force_out, 1'b1);
        xfer(1'b1, 12'h008, 8'h5a, `PCC_RESP_SLVERR);
        xfer(1'b0, 12'h008, 8'h00, `PCC_RESP_SLVERR);
        oscillator_enable_in <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({crystal_osc_enable_out, pll_enable_out}, 2'h0);
        oscillator_enable_in <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(CTL, 8'h20);
        rd(BW, 8'h00);
        complete_run();
    end
endmodule // pcc_pll_clock_control_tb

bind pcc_pll_clock_control pcc_checker #(.ADDR_W(ADDR_W)) chk_i (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .oscillator_enable_in, .vco_range_is_zero,
    .crystal_osc_enable_out, .pll_enable_out, .prescaler_field_out, .vco_range_power_field_out,
    .auto_bandwidth_out, .lock_interrupt_out);
